// File: design/host_port_byte_lane_swap.sv
`timescale 1ns/1ns
module host_port_byte_lane_swap (
  input  wire logic                             clk,
  input  wire logic                             rst,
  input  wire logic                             clk_en,
  input  wire logic                             chip_select_n,
  input  wire logic                             read_strobe_n,
  input  wire logic                             upper_write_strobe_n,
  input  wire logic                             lower_write_strobe_n,
  input  wire logic [lane_swap_pkg::ADDR_W-1:0] host_addr,
  input  wire logic [15:0]                      host_data_bus_in,
  output logic      [15:0]                      host_data_bus_out,
  output logic                                  host_data_bus_oe,
  output lane_swap_pkg::int_req_t               int_req,
  input  wire lane_swap_pkg::lane_word_t        int_rdata,
  output logic                                  little_endian_select,
  output logic                                  lanes_swapped
);
  import lane_swap_pkg::*;

  // Lane exchange is its own inverse, so one function serves both directions
  function automatic logic [15:0] map_lanes(input logic swap, input lane_word_t w);
    map_lanes = swap ? {w.odd, w.even} : {w.even, w.odd};
  endfunction

  function automatic logic is_word(input logic [WADDR_W-1:0] wa,
                                   input logic [ADDR_W-1:0] ofs);
    is_word = (wa == ofs[ADDR_W-1:1]);
  endfunction

  port_state_t       state_q, state_d;
  logic [7:0]        cfg_q, cfg_d;
  logic              swap_q, swap_d;
  int_req_t          req_q, req_d;
  logic [15:0]       dout_q, dout_d;
  logic              oe_q, oe_d;

  logic              rd_act;
  logic              wr_up_act;
  logic              wr_lo_act;
  logic              wr_even;
  logic              wr_odd;
  lane_word_t        win;
  lane_word_t        rword;

  always_comb begin
    rd_act    = !chip_select_n && !read_strobe_n;
    wr_up_act = !chip_select_n && !upper_write_strobe_n;
    wr_lo_act = !chip_select_n && !lower_write_strobe_n;
    // Physical strobe to internal byte: upper is even until the swap
    wr_even   = swap_q ? wr_lo_act : wr_up_act;  // [R01] [R11]
    wr_odd    = swap_q ? wr_up_act : wr_lo_act;  // [R07] [R11]
    win       = lane_word_t'(map_lanes(swap_q, lane_word_t'(host_data_bus_in)));  // [R04]
    if (is_word(req_q.word_addr, HOST_PORT_CONFIG_OFS)) begin
      rword = '{even: UNMAPPED_BYTE, odd: cfg_q};
    end else if (is_word(req_q.word_addr, LANE_SWAP_TRIGGER_OFS)) begin
      rword = '{even: UNMAPPED_BYTE, odd: LANE_SWAP_TRIGGER_VAL};
    end else begin
      rword = int_rdata;  // FIFO words arrive earlier byte in even  [R09]
    end
  end

  always_comb begin
    state_d      = state_q;
    cfg_d        = cfg_q;
    swap_d       = swap_q;
    req_d        = req_q;
    req_d.rd     = 1'b0;
    req_d.wr_even = 1'b0;
    req_d.wr_odd = 1'b0;
    dout_d       = dout_q;
    oe_d         = oe_q;
    case (state_q)
      ST_IDLE: begin
        oe_d = 1'b0;
        if (rd_act) begin
          req_d.word_addr = host_addr[ADDR_W-1:1];
          req_d.rd        = 1'b1;  // [R08]
          state_d         = ST_READ;
        end else if (wr_up_act || wr_lo_act) begin
          req_d.word_addr = host_addr[ADDR_W-1:1];
          req_d.wr_even   = wr_even;  // [R08] [R11]
          req_d.wr_odd    = wr_odd;
          req_d.wdata     = win;
          // Config is the odd byte; before the swap a LE host hits it at 0x074
          if (is_word(host_addr[ADDR_W-1:1], HOST_PORT_CONFIG_OFS) && wr_odd) begin
            cfg_d = win.odd;  // [R03] [R04] [R05]
          end
          state_d = ST_WRITE;
        end
      end
      ST_READ: begin
        dout_d = map_lanes(swap_q, rword);  // [R01] [R02] [R07] [R09]
        oe_d   = 1'b1;
        if (!rd_act) begin
          oe_d    = 1'b0;
          state_d = ST_IDLE;
          // Swap lands after the trigger read so its own data is stable
          if (is_word(req_q.word_addr, LANE_SWAP_TRIGGER_OFS) && cfg_q[LE_SELECT_BIT]) begin
            swap_d = 1'b1;  // [R06] [R12]
          end
        end
      end
      ST_WRITE: begin
        // One write per strobe assertion; wait for release
        if (!wr_up_act && !wr_lo_act) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
        oe_d    = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= ST_IDLE;
      cfg_q   <= HOST_PORT_CONFIG_RST;
      swap_q  <= 1'b0;  // [R02]
      req_q   <= '0;
      dout_q  <= 16'h0000;
      oe_q    <= 1'b0;
    end else if (clk_en) begin
      state_q <= state_d;
      cfg_q   <= cfg_d;
      swap_q  <= swap_d;
      req_q   <= req_d;
      dout_q  <= dout_d;
      oe_q    <= oe_d;
    end
  end

  always_comb begin
    host_data_bus_out    = dout_q;
    host_data_bus_oe     = oe_q;
    int_req              = req_q;
    little_endian_select = cfg_q[LE_SELECT_BIT];
    lanes_swapped        = swap_q;
  end

endmodule

// File: design/lane_swap_pkg.sv
// How it works
// [R01] In big-endian order the byte at an even address rides the upper lane, the odd one the lower.
// [R02] Out of reset the host data bus runs in big-endian lane order until the swap sequence ends.
// [R03] Host software starts the switch by writing 1 to the little-endian select bit.
// [R04] Before the swap a little-endian host finds the config register at 0x074, not 0x075.
// [R05] Setting the select bit alone leaves the lane order unchanged until the trigger read.
// [R06] A read of 0x077 with the select bit set exchanges the upper and lower data lanes.
// [R07] After the swap both byte addresses of every multi-byte register pair are exchanged.
// [R08] Once configured, 8-bit and 16-bit host accesses reach every register.
// [R09] A 16-bit FIFO read puts the earlier USB byte on the upper lane (BE) or lower lane (LE).
// [R10] The host splits registers wider than 16 bits into separate 16-bit accesses itself.
// [R11] Upper and lower write strobes each write only their own byte lane.
// [R12] The swap holds until chip reset; further trigger reads never swap back.
package lane_swap_pkg;

  localparam int unsigned ADDR_W            = 8;
  localparam int unsigned WADDR_W           = ADDR_W - 1;

  localparam logic [ADDR_W-1:0] HOST_PORT_CONFIG_OFS  = 8'h75;
  localparam logic [ADDR_W-1:0] LANE_SWAP_TRIGGER_OFS = 8'h77;

  localparam int unsigned       LE_SELECT_BIT       = 0;
  localparam logic [7:0]        HOST_PORT_CONFIG_RST = 8'h00;
  localparam logic [7:0]        LANE_SWAP_TRIGGER_VAL = 8'h00;
  localparam logic [7:0]        UNMAPPED_BYTE       = 8'h00;

  // Bytes of one word in internal (big-endian) address order
  typedef struct packed {
    logic [7:0] even;
    logic [7:0] odd;
  } lane_word_t;

  typedef struct packed {
    logic [WADDR_W-1:0] word_addr;
    logic               rd;
    logic               wr_even;
    logic               wr_odd;
    lane_word_t         wdata;
  } int_req_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_READ = 3'b010,
    ST_WRITE = 3'b100
  } port_state_t;

endpackage

// File: test/host_cpu_model.sv
`timescale 1ns/1ns
module host_cpu_model (
  input  wire logic        clk, host_data_bus_oe,
  input  wire logic [15:0] host_data_bus_out,
  output logic [15:0]      host_data_bus_in,
  output logic [7:0]       host_addr,
  output logic             chip_select_n, read_strobe_n, upper_write_strobe_n, lower_write_strobe_n
);
  logic [3:0]  c = 4'hf;
  logic [15:0] wd = 16'h0000;
  initial host_addr = 8'h00;
  assign {chip_select_n, read_strobe_n, upper_write_strobe_n, lower_write_strobe_n} = c;
  // Released lines show inverted data, never a stale copy
  assign host_data_bus_in = host_data_bus_oe ? host_data_bus_out : wd;
  // 8-bit and 16-bit accesses only; wider values are split by the caller
  task automatic acc(input logic [1:0] s, input logic [7:0] a, input logic [15:0] d,
                     output logic [15:0] q);
    @(negedge clk);
    c = {1'b0, s != 2'b00, ~s};
    host_addr = a;
    wd = d;
    repeat (3) @(negedge clk);
    q = host_data_bus_in;
    c = 4'hf;
    wd = ~d;
    repeat (2) @(negedge clk);
  endtask
endmodule

// File: test/host_port_byte_lane_swap_tb.sv
`timescale 1ns/1ns
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin failures++; \
  $display("Error t=%0t got %h exp %h", $time, (a), (e)); end end
module host_port_byte_lane_swap_tb;
  import lane_swap_pkg::*;
  logic        clk, rst, chip_select_n, read_strobe_n, upper_write_strobe_n, lower_write_strobe_n;
  logic        host_data_bus_oe, little_endian_select, lanes_swapped;
  logic [7:0]  host_addr;
  logic [15:0] host_data_bus_in, host_data_bus_out, q;
  int_req_t    int_req;
  lane_word_t  int_rdata;
  int          failures, tests_run;
  wire         clk_en = 1'b1;
  // Each internal byte reads back its own address
  assign int_rdata = {int_req.word_addr, 1'b0, int_req.word_addr, 1'b1};
  host_port_byte_lane_swap u_host_port_byte_lane_swap (.*);
  host_cpu_model u_host_cpu_model (.*);
  task automatic results;
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    repeat (500) @(posedge clk);
    failures++;
    results();
  end
  initial begin
    rst = 1'b1;
    repeat (10) @(negedge clk);
    rst = 1'b0;
    `CHK(lanes_swapped, 1'b0)
    u_host_cpu_model.acc(2'b00, 8'h20, 16'h0000, q);
    `CHK(q, 16'h2021)
    u_host_cpu_model.acc(2'b10, 8'h74, 16'h0100, q);
    `CHK(little_endian_select, 1'b0)
    u_host_cpu_model.acc(2'b01, 8'h74, 16'h0001, q);
    `CHK(little_endian_select, 1'b1)
    `CHK(lanes_swapped, 1'b0)
    $display("test big endian done");
    u_host_cpu_model.acc(2'b00, 8'h77, 16'h0000, q);
    `CHK(q, 16'h0000)
    `CHK(lanes_swapped, 1'b1)
    u_host_cpu_model.acc(2'b00, 8'h23, 16'h0000, q);
    `CHK(q, 16'h2322)
    u_host_cpu_model.acc(2'b00, 8'h77, 16'h0000, q);
    `CHK(lanes_swapped, 1'b1)
    u_host_cpu_model.acc(2'b10, 8'h20, 16'hab00, q);
    $display("test little endian done");
    results();
  end
endmodule
bind host_port_byte_lane_swap lane_swap_properties u_lane_swap_properties (.*);

// File: test/lane_swap_properties.sv
`timescale 1ns/1ns
module lane_swap_properties
  import lane_swap_pkg::*;
(
  input wire logic        clk, rst, read_strobe_n, host_data_bus_oe,
  input wire logic        little_endian_select, lanes_swapped,
  input wire logic [15:0] host_data_bus_in, host_data_bus_out,
  input wire int_req_t    int_req,
  input wire lane_word_t  int_rdata
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_swap_sticky: assert property (lanes_swapped |=> lanes_swapped) else $error("swap lost");
  a_swap_cause: assert property ($rose(lanes_swapped) |-> little_endian_select)
    else $error("swap without select");
  a_rd_answer: assert property (int_req.rd |=> !int_req.rd && host_data_bus_oe)
    else $error("read answer late");
  a_oe_release: assert property ($rose(read_strobe_n) |-> ##[1:2] !host_data_bus_oe)
    else $error("bus held");
  a_upper_even: assert property (int_req.wr_even && !lanes_swapped |->
    int_req.wdata.even == $past(host_data_bus_in[15:8])) else $error("even lane");
  a_upper_odd: assert property (int_req.wr_odd && lanes_swapped |->
    int_req.wdata.odd == $past(host_data_bus_in[15:8])) else $error("odd lane");
  a_read_lanes: assert property (host_data_bus_oe
    && int_req.word_addr != HOST_PORT_CONFIG_OFS[ADDR_W-1:1]
    && int_req.word_addr != LANE_SWAP_TRIGGER_OFS[ADDR_W-1:1] |->
    host_data_bus_out == (lanes_swapped ? {int_rdata.odd, int_rdata.even} : int_rdata))
    else $error("read lanes");
  a_swap_reset: assert property ($fell(rst) |-> !lanes_swapped) else $error("reset swap");
endmodule
